/* File: include/tspc_pkg.sv */
// Shared constants of the three-wire serial port control block
package tspc_pkg;
   // Register byte addresses
   localparam logic [15:0] ADDR_MODE = 16'hFF88;
   localparam logic [15:0] ADDR_SHIFT = 16'hFF84;
   localparam logic [15:0] ADDR_TXBUF = 16'hFF8C;
   localparam logic [15:0] ADDR_CLKSEL = 16'hFF90;
   localparam logic [15:0] ADDR_STATUS = 16'hFF94;
   localparam logic [15:0] ADDR_RXDATA = 16'hFF98;
   localparam logic [15:0] ADDR_BITOP = 16'hFF9C;
   // Mode register fields
   localparam int MODE_EN = 7;
   localparam int MODE_TXM = 6;
   localparam int MODE_SSE = 5;
   localparam int MODE_DIR = 4;
   localparam int MODE_ACT = 0;
   localparam logic [7:0] MODE_WMASK = 8'hF0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // Clock select fields
   localparam int CLK_POL = 4;
   localparam logic [4:0] CLKSEL_RESET = 5'h00;
   localparam logic [2:0] CKS_EXTERNAL = 3'h7;
   // Status fields
   localparam int STAT_DONE = 0;
   localparam int STAT_RXV = 1;
   // Single-bit write port fields
   localparam int BITOP_VAL = 7;
   // Bits per transfer
   localparam logic [3:0] XFER_BITS = 4'h8;
endpackage : tspc_pkg

/* File: src/tspc_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tspc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : tspc_sync
`default_nettype wire

/* File: src/tspc_buf2.sv */
// Small valid/ready buffer for received bytes
`timescale 1ns/1ps
`default_nettype none
module tspc_buf2 #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_reg] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         if (pop)
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : tspc_buf2
`default_nettype wire

/* File: src/tspc_top.sv */
// Three-wire serial port with APB register access
// Functional notes
// - Disabled port does no transfers, pins released
// - Clearing enable asynchronously resets port circuitry
// - That reset clears active flag and shift
// - System reset zeroes mode register, port off
// - Mode register takes single-bit and byte writes
// - Mode fields: dir4, sse5, txmode6, en7, active0
// - Transfer uses only clock, out, in lines
// - Enable set makes port ready to transfer
// - Transmit buffer write starts transmit and receive
// - Shift register read starts reception only
// - Slave select pin used only in slave mode when enabled
// - Transmit mode off: receive only, out unused
// - Slave select high holds or suspends transfer
// - Active set at start; eight bits end it
`timescale 1ns/1ps
`default_nettype none
module tspc_top #(
   parameter int ADDR_W = 16,
   parameter int RXBUF_DEPTH = 2
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial clock pin
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe_n,
   // Serial data pins
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_n,
   // Slave select pin
   input wire logic ssi_n,
   // Transfer done flag
   output logic done_flag
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] mode_reg, tx_buffer_reg, shift_reg, div_reg, rx_data, half_period;
   logic [4:0] clksel_reg;
   logic [31:0] prdata_reg;
   logic [3:0] bit_cnt_reg;
   logic [2:0] pins_s;
   logic done_reg, active_reg, so_bit_reg, sck_lvl_reg, sck_prev_reg, core_rst_n, sck_norm;
   logic en, txm, sse, dir, slave, gate;
   logic setup, access, wr, rd;
   logic wr_mode, wr_bitop, wr_tx, rd_shift, rd_rx, wr_stat, wr_clk;
   logic mapped, start_ok, start, lead_ev, trail_ev, done_ev, rx_in_ready, rx_valid;

   assign en = mode_reg[tspc_pkg::MODE_EN];
   assign txm = mode_reg[tspc_pkg::MODE_TXM];
   assign sse = mode_reg[tspc_pkg::MODE_SSE];
   assign dir = mode_reg[tspc_pkg::MODE_DIR];
   assign slave = (clksel_reg[2:0] == tspc_pkg::CKS_EXTERNAL);
   // Cleared enable resets the shifting logic without a clock
   assign core_rst_n = presetn & en;

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign pready = 1'b1;
   assign mapped = paddr[15:0] inside {tspc_pkg::ADDR_MODE, tspc_pkg::ADDR_SHIFT,
      tspc_pkg::ADDR_TXBUF, tspc_pkg::ADDR_CLKSEL, tspc_pkg::ADDR_STATUS,
      tspc_pkg::ADDR_RXDATA, tspc_pkg::ADDR_BITOP};
   assign pslverr = access && !mapped;
   assign wr_mode = wr && paddr[15:0] == tspc_pkg::ADDR_MODE;
   assign wr_bitop = wr && paddr[15:0] == tspc_pkg::ADDR_BITOP;
   assign wr_tx = wr && paddr[15:0] == tspc_pkg::ADDR_TXBUF;
   assign wr_clk = wr && paddr[15:0] == tspc_pkg::ADDR_CLKSEL;
   assign wr_stat = wr && paddr[15:0] == tspc_pkg::ADDR_STATUS;
   assign rd_shift = rd && paddr[15:0] == tspc_pkg::ADDR_SHIFT;
   assign rd_rx = rd && paddr[15:0] == tspc_pkg::ADDR_RXDATA;
   assign prdata = prdata_reg;

   // Read data captured in setup so it stands through the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h0000_0000;
      else if (setup && !pwrite)
      begin
         unique case (paddr[15:0])
            tspc_pkg::ADDR_MODE: prdata_reg <= {24'h00_0000, mode_reg[7:4], 3'h0,
               active_reg};
            tspc_pkg::ADDR_SHIFT: prdata_reg <= {24'h00_0000, shift_reg};
            tspc_pkg::ADDR_TXBUF: prdata_reg <= {24'h00_0000, tx_buffer_reg};
            tspc_pkg::ADDR_CLKSEL: prdata_reg <= {27'h000_0000, clksel_reg};
            tspc_pkg::ADDR_STATUS: prdata_reg <= {30'h0000_0000, rx_valid, done_reg};
            tspc_pkg::ADDR_RXDATA: prdata_reg <= {24'h00_0000, rx_data};
            default: prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_reg <= tspc_pkg::MODE_RESET;
      else if (wr_mode)
         mode_reg <= pwdata[7:0] & tspc_pkg::MODE_WMASK;
      else if (wr_bitop && (pwdata[2:0] > 3'h3))
         mode_reg[pwdata[2:0]] <= pwdata[tspc_pkg::BITOP_VAL];
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clksel_reg <= tspc_pkg::CLKSEL_RESET;
      else if (wr_clk)
         clksel_reg <= pwdata[4:0];
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tx_buffer_reg <= 8'h00;
      else if (wr_tx)
         tx_buffer_reg <= pwdata[7:0];
   end
   // Set beats clear when both land in one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         done_reg <= 1'b0;
      else if (done_ev)
         done_reg <= 1'b1;
      else if (wr_stat && pwdata[tspc_pkg::STAT_DONE])
         done_reg <= 1'b0;
   end
   assign done_flag = done_reg;

   ////////////////////////////////////////////////////////////////////////
   // Pin inputs
   tspc_sync #(.W(3)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({ssi_n, si_in, sck_in}),
      .q(pins_s)
   );

   // Slave select only counts in slave mode with its use bit on
   assign gate = en && slave && sse && pins_s[2];

   ////////////////////////////////////////////////////////////////////////
   // Start: refused while busy or while the receive buffer has no room
   assign start_ok = en && !active_reg && rx_in_ready;
   assign start = start_ok && ((wr_tx && txm) || (rd_shift && !txm));
   always_ff @(posedge pclk or negedge core_rst_n)
   begin
      if (!core_rst_n)
         active_reg <= 1'b0;
      else if (start)
         active_reg <= 1'b1;
      else if (done_ev)
         active_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock edges: divider in master mode, sampled pin in slave mode
   assign half_period = 8'h01 << clksel_reg[2:0];
   assign sck_norm = pins_s[0] ^ clksel_reg[tspc_pkg::CLK_POL];
   always_ff @(posedge pclk or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         div_reg <= 8'h00;
         sck_lvl_reg <= 1'b1;
         sck_prev_reg <= 1'b1;
      end
      else
      begin
         sck_prev_reg <= sck_norm;
         if (!active_reg || slave || gate)
         begin
            div_reg <= 8'h00;
            sck_lvl_reg <= 1'b1;
         end
         else if (div_reg == half_period - 8'h01)
         begin
            div_reg <= 8'h00;
            sck_lvl_reg <= !sck_lvl_reg;
         end
         else
            div_reg <= div_reg + 8'h01;
      end
   end
   always_comb
   begin
      lead_ev = 1'b0;
      trail_ev = 1'b0;
      if (active_reg && !gate)
      begin
         if (slave)
         begin
            lead_ev = sck_prev_reg && !sck_norm;
            trail_ev = !sck_prev_reg && sck_norm;
         end
         else if (div_reg == half_period - 8'h01)
         begin
            lead_ev = sck_lvl_reg;
            trail_ev = !sck_lvl_reg;
         end
      end
   end
   assign done_ev = trail_ev && (bit_cnt_reg == tspc_pkg::XFER_BITS - 4'h1);

   ////////////////////////////////////////////////////////////////////////
   // Shifter: output on leading edge, sample on trailing edge
   always_ff @(posedge pclk or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         so_bit_reg <= 1'b0;
      end
      else if (start)
      begin
         // The buffer write lands in this same edge, so take the bus word
         shift_reg <= wr_tx ? pwdata[7:0] : tx_buffer_reg;
         bit_cnt_reg <= 4'h0;
      end
      else
      begin
         if (lead_ev)
            so_bit_reg <= txm && (dir ? shift_reg[0] : shift_reg[7]);
         if (trail_ev)
         begin
            shift_reg <= dir ? {pins_s[1], shift_reg[7:1]} : {shift_reg[6:0], pins_s[1]};
            bit_cnt_reg <= done_ev ? 4'h0 : bit_cnt_reg + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive buffer; a stalled reader holds off new starts
   tspc_buf2 #(.W(8), .DEPTH(RXBUF_DEPTH)) u_rxbuf (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(done_ev),
      .in_ready(rx_in_ready),
      .in_data(dir ? {pins_s[1], shift_reg[7:1]} : {shift_reg[6:0], pins_s[1]}),
      .out_valid(rx_valid),
      .out_ready(rd_rx),
      .out_data(rx_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pins: only clock, out and in lines carry the transfer
   assign sck_out = sck_lvl_reg ^ clksel_reg[tspc_pkg::CLK_POL];
   assign sck_oe_n = !(en && !slave);
   assign so_out = so_bit_reg;
   assign so_oe_n = !(en && txm);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_disabled_idle;
      @(posedge pclk) disable iff (!presetn)
      !en |-> !active_reg && shift_reg == 8'h00 && sck_oe_n && so_oe_n;
   endproperty
   a_disabled_idle: assert property (p_disabled_idle)
      else $error("disabled port not idle");
   property p_clear_en;
      @(posedge pclk) disable iff (!presetn)
      wr_mode && !pwdata[tspc_pkg::MODE_EN] |=> !active_reg && shift_reg == 8'h00;
   endproperty
   a_clear_en: assert property (p_clear_en)
      else $error("enable clear did not reset core");
   property p_mode_write;
      @(posedge pclk) disable iff (!presetn)
      wr_mode |=> mode_reg == ($past(pwdata[7:0]) & 8'hF0) && mode_reg[3:0] == 4'h0;
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode register write wrong");
   property p_bitop;
      @(posedge pclk) disable iff (!presetn)
      wr_bitop && pwdata[2:0] == 3'h7 |=> en == $past(pwdata[7]) && $stable(mode_reg[6:0]);
   endproperty
   a_bitop: assert property (p_bitop)
      else $error("single-bit write wrong");
   property p_tx_start;
      @(posedge pclk) disable iff (!presetn)
      wr_tx && en && txm && !active_reg && rx_in_ready |=> active_reg
         && shift_reg == $past(pwdata[7:0]);
   endproperty
   a_tx_start: assert property (p_tx_start)
      else $error("tx write did not start transfer");
   property p_rx_start;
      @(posedge pclk) disable iff (!presetn)
      rd_shift && en && !txm && !active_reg && rx_in_ready |=> active_reg ##0 so_oe_n;
   endproperty
   a_rx_start: assert property (p_rx_start)
      else $error("shift read did not start reception");
   property p_done;
      @(posedge pclk) disable iff (!presetn)
      done_ev |=> !active_reg && done_reg && bit_cnt_reg == 4'h0;
   endproperty
   a_done: assert property (p_done)
      else $error("completion not flagged");
   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      gate && active_reg |=> $stable(bit_cnt_reg) && $stable(shift_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("transfer moved while deselected");
   property p_master_clk;
      @(posedge pclk) disable iff (!presetn)
      en && !slave && active_reg && !done_ev && !wr_mode && !wr_bitop
         && div_reg == half_period - 8'h01 |=> sck_lvl_reg != $past(sck_lvl_reg);
   endproperty
   a_master_clk: assert property (p_master_clk)
      else $error("master clock not toggling");

   c_tx_done: cover property (@(posedge pclk) disable iff (!presetn) done_ev && txm);
   c_rx_done: cover property (@(posedge pclk) disable iff (!presetn) done_ev && !txm);
   c_held: cover property (@(posedge pclk) disable iff (!presetn) gate && active_reg);
   c_buf_full: cover property (@(posedge pclk) disable iff (!presetn) !rx_in_ready);
endmodule : tspc_top
`default_nettype wire

/* File: tb/tspc_peer.sv */
// Behavioural serial peer on the far side of the three-wire port
`timescale 1ns/1ps
`default_nettype none
module tspc_peer (
   // Resolved lines
   input wire logic sck,
   input wire logic so,
   // Lines driven by the peer
   output logic si,
   output logic sck_gen
);
   logic [7:0] tx_sh;
   logic [7:0] rx;
   logic started;

   initial
   begin
      sck_gen = 1'b1;
      si = 1'b0;
      tx_sh = 8'h00;
      rx = 8'h00;
      started = 1'b0;
   end

   // First bit is presented at load, later bits follow each leading edge after the first
   always @(negedge sck)
   begin
      if (started)
      begin
         si <= tx_sh[7];
         tx_sh <= {tx_sh[6:0], 1'b0};
      end
      started <= 1'b1;
   end

   always @(posedge sck)
      rx <= {rx[6:0], so};

   task automatic load(input logic [7:0] b);
      si = b[7];
      tx_sh = {b[6:0], 1'b0};
      started = 1'b0;
   endtask : load

   // Clock stands high between frames; offset keeps edges off pclk
   task automatic frame;
      #3;
      repeat (8)
      begin
         #80 sck_gen = 1'b0;
         #80 sck_gen = 1'b1;
      end
   endtask : frame
endmodule : tspc_peer
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the three-wire serial port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sck_out, sck_oe_n, so_out, so_oe_n, ssi_n, done_flag, si, sck_gen;
   logic [7:0] d, p;
   logic [7:0] ex [2];
   int miscompares, n_checks, k, i;
   wire logic sck_w = sck_oe_n ? sck_gen : sck_out;
   // Released data line shows the inverse, never a stale copy
   wire logic so_w = so_oe_n ? ~so_out : so_out;

   tspc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
      .si_in(si), .so_out(so_out), .so_oe_n(so_oe_n), .ssi_n(ssi_n),
      .done_flag(done_flag));
   tspc_peer peer (.sck(sck_w), .so(so_w), .si(si), .sck_gen(sck_gen));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] ord(input logic [7:0] b, input logic lsb);
      logic [7:0] r;
      for (int j = 0; j < 8; j++)
         r[j] = lsb ? b[7-j] : b[j];
      return r;
   endfunction : ord

   // Idle edge first, so a release never meets the next setup in one step
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] dat);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Callers then see what the access edge wrote, not the old value
      @(posedge pclk);
   endtask : apb

   task automatic wait_done;
      for (int c = 0; c < 3000 && done_flag !== 1'b1; c++)
         @(posedge pclk);
      `CHK("done_flag", 1'b1, done_flag)
      apb(1'b0, tspc_pkg::ADDR_MODE, 32'h0);
      `CHK("idle", 1'b0, rd[0])
   endtask : wait_done

   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial
   begin
      #900000;
      miscompares++;
      tally_and_finish;
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      ssi_n = 1'b0;
      miscompares = 0;
      n_checks = 0;
      d = $urandom(28605);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, tspc_pkg::ADDR_MODE, 32'h0);
      `CHK("mode_reset", 32'h0000_0000, rd)
      `CHK("pins_free", 3'b110, {sck_oe_n, so_oe_n, done_flag})
      apb(1'b0, 16'hFF80, 32'h0);
      `CHK("unmapped_err", 1'b1, err)
      apb(1'b1, tspc_pkg::ADDR_MODE, 32'h0000_007F);
      apb(1'b0, tspc_pkg::ADDR_MODE, 32'h0);
      `CHK("mode_reserved", 32'h0000_0070, rd)
      `CHK("off_oe", 2'b11, {sck_oe_n, so_oe_n})
      apb(1'b1, tspc_pkg::ADDR_BITOP, 32'h0000_0006);
      apb(1'b1, tspc_pkg::ADDR_BITOP, 32'h0000_0082);
      apb(1'b0, tspc_pkg::ADDR_MODE, 32'h0);
      `CHK("mode_bitop", 32'h0000_0030, rd)
      apb(1'b1, tspc_pkg::ADDR_MODE, 32'h0);
      $display("test registers done");
      // Two transfers fill the receive buffer, the third must be refused
      for (k = 0; k < 2; k++)
      begin
         apb(1'b1, tspc_pkg::ADDR_MODE, 32'h0);
         apb(1'b1, tspc_pkg::ADDR_CLKSEL, 32'h2 + ($urandom % 2));
         apb(1'b1, tspc_pkg::ADDR_MODE, {24'h0, 3'h2, k[0], 4'h0});
         apb(1'b1, tspc_pkg::ADDR_MODE, {24'h0, 3'h6, k[0], 4'h0});
         `CHK("master_oe", 2'b00, {sck_oe_n, so_oe_n})
         for (i = 0; i < 3; i++)
         begin
            p = $urandom;
            d = $urandom;
            peer.load(p);
            apb(1'b1, tspc_pkg::ADDR_TXBUF, {24'h0, d});
            apb(1'b0, tspc_pkg::ADDR_MODE, 32'h0);
            `CHK("active", i < 2, rd[0])
            if (i < 2)
            begin
               ex[i] = ord(p, k[0]);
               wait_done;
               `CHK("peer_rx", ord(d, k[0]), peer.rx)
               apb(1'b1, tspc_pkg::ADDR_STATUS, 32'h1);
            end
         end
         for (i = 0; i < 2; i++)
         begin
            apb(1'b0, tspc_pkg::ADDR_RXDATA, 32'h0);
            `CHK("rx_data", {24'h0, ex[i]}, rd)
         end
         apb(1'b0, tspc_pkg::ADDR_STATUS, 32'h0);
         `CHK("rx_empty", 1'b0, rd[1])
         $display("test master pass %0d done", k);
      end
      apb(1'b1, tspc_pkg::ADDR_MODE, 32'h0000_0080);
      `CHK("rx_only_oe", 1'b1, so_oe_n)
      p = $urandom;
      peer.load(p);
      apb(1'b0, tspc_pkg::ADDR_SHIFT, 32'h0);
      wait_done;
      apb(1'b0, tspc_pkg::ADDR_RXDATA, 32'h0);
      `CHK("rx_only", {24'h0, p}, rd)
      apb(1'b1, tspc_pkg::ADDR_STATUS, 32'h1);
      $display("test receive only done");
      apb(1'b1, tspc_pkg::ADDR_MODE, 32'h0000_00C0);
      apb(1'b1, tspc_pkg::ADDR_TXBUF, 32'h0000_005A);
      repeat (12) @(posedge pclk);
      apb(1'b1, tspc_pkg::ADDR_MODE, 32'h0);
      apb(1'b0, tspc_pkg::ADDR_SHIFT, 32'h0);
      `CHK("abort_shift", 32'h0, rd)
      apb(1'b0, tspc_pkg::ADDR_MODE, 32'h0);
      `CHK("abort_mode", 32'h0, rd)
      `CHK("abort_done", 1'b0, done_flag)
      `CHK("abort_pins", 2'b11, {sck_oe_n, so_oe_n})
      $display("test abort done");
      apb(1'b1, tspc_pkg::ADDR_CLKSEL, 32'h7);
      apb(1'b1, tspc_pkg::ADDR_MODE, 32'h0000_0060);
      ssi_n <= 1'b1;
      apb(1'b1, tspc_pkg::ADDR_BITOP, 32'h0000_0087);
      `CHK("slave_oe", 2'b10, {sck_oe_n, so_oe_n})
      d = $urandom;
      p = $urandom;
      peer.load(p);
      apb(1'b1, tspc_pkg::ADDR_TXBUF, {24'h0, d});
      peer.frame;
      repeat (4) @(posedge pclk);
      apb(1'b0, tspc_pkg::ADDR_MODE, 32'h0);
      `CHK("held", 2'b10, {rd[0], done_flag})
      ssi_n <= 1'b0;
      repeat (2) @(posedge pclk);
      peer.load(p);
      peer.frame;
      wait_done;
      `CHK("slave_peer_rx", d, peer.rx)
      apb(1'b0, tspc_pkg::ADDR_RXDATA, 32'h0);
      `CHK("slave_rx", {24'h0, p}, rd)
      $display("test slave done");
      tally_and_finish;
   end
endmodule : testbench
`default_nettype wire
